// file: rtl/dssq_pkg.sv
// Constants and types shared by the start/stop sequencer
`default_nettype none
package dssq_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned MS_CYC_DEF  = CLK_HZ / 1000;
  localparam int unsigned HALT_MIN_MS = 100;
  // More than the minimum, so one extra cycle
  localparam int unsigned HALT_CYC_DEF = HALT_MIN_MS * MS_CYC_DEF + 1;
  localparam int unsigned FINAL_RAMP_MS = 10000;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_REF    = 8'h04;
  localparam logic [7:0] A_INSPD  = 8'h08;
  localparam logic [7:0] A_TRIM   = 8'h0C;
  localparam logic [7:0] A_ACCEL  = 8'h10;
  localparam logic [7:0] A_DECEL  = 8'h14;
  localparam logic [7:0] A_FINAL  = 8'h18;
  localparam logic [7:0] A_FAST   = 8'h1C;
  localparam logic [7:0] A_INPER  = 8'h20;
  localparam logic [7:0] A_DELAY  = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_SPEED  = 8'h2C;
  // ==========================================================
  // Control bits
  localparam int B_LOCAL    = 0;
  localparam int B_STOPCST  = 1;
  localparam int B_FASTCST  = 2;
  localparam int B_FREEZE   = 3;
  localparam int B_TWOWIRE  = 4;
  localparam int B_TRIPCLR  = 8;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] FINAL_RST = 16'(FINAL_RAMP_MS);
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_DEC = 2'b11;
  // ==========================================================
  // Input vector positions
  localparam int I_FWD = 0, I_REV = 1, I_INCH = 2, I_HALT = 3, I_FAST = 4, I_COAST = 5;
  localparam int I_EN = 6, I_TRIP = 7, I_KRUN = 8, I_KSTOP = 9, I_KINCH = 10, I_KDIR = 11;
  localparam int N_IN = 12;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_RUN   = 7'b000_0010,
    ST_INCH  = 7'b000_0100,
    ST_DECEL = 7'b000_1000,
    ST_FINAL = 7'b001_0000,
    ST_DELAY = 7'b010_0000,
    ST_TRIP  = 7'b100_0000
  } dssq_state_t;
endpackage
`default_nettype wire

// file: rtl/dssq_ramp.sv
// Linear ramp generator stepping one unit per due slot
`default_nettype none
module dssq_ramp
  import dssq_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // System
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ms_tick,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] target,
  input  wire logic [15:0]      period,
  // Result
  output logic [WIDTH-1:0]      value
);
  localparam logic [31:0] FULL = 32'((1 << WIDTH) - 1);
  logic [31:0] acc_r;
  logic [31:0] acc_sum;

  initial
  begin
    if (WIDTH < 2 || WIDTH > 16) $error("dssq_ramp WIDTH out of range");
  end

  assign acc_sum = ms_tick ? acc_r + FULL : acc_r;

  // Full scale per period: ms ticks add full scale, each step spends one period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value <= '0;
      acc_r <= '0;
    end
    else if (load || period == ZERO16)
    begin
      value <= target;
      acc_r <= '0;
    end
    else if (value == target)
      acc_r <= '0;
    else if (acc_sum >= 32'(period))
    begin
      acc_r <= acc_sum - 32'(period);
      value <= (value < target) ? value + 1'b1 : value - 1'b1;
    end
    else
      acc_r <= acc_sum;
  end
endmodule
`default_nettype wire

// file: rtl/dssq_top.sv
// Drive start/stop sequencer with AXI4-Lite configuration
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`default_nettype none
// Overview of operation
// - Remote run ramps to reference, holds
// - Inch ramps to inch speed while held
// - Run key starts, runs until stop key
// - Inch key inches; release starts stop
// - Run and inch exclusive; change via stop
// - Motion flag from start until quench
// - No-fault flag true unless tripped
// - Ramp stop default, final ramp 10 s
// - Decel to zero, then trim to zero
// - Stack stays on through stop delay
// - Zero decel or freeze: final ramp
// - Freewheel: speed zero, stack off now
// - Fast stop overrides all run requests
// - Forced freewheel quenches, beats fast stop
// - Trip freewheels, held until reset
// - Halt low over 100 ms stops fully
// - Stack enable low forces stack off
// - Two-wire both directions: stop
// - Halt high latches runs; low clears
// - Inch never latched
// - Halt unwired: run only while held
// - Forced stops same local or remote
module dssq_top
  import dssq_pkg::*;
#(
  parameter int unsigned MS_CYC   = MS_CYC_DEF,
  parameter int unsigned HALT_CYC = HALT_CYC_DEF,
  parameter int          SPD_W    = 16
) (
  // System
  input  wire logic             CLK_SYS,
  input  wire logic             ARST_N,
  // Remote digital inputs
  input  wire logic             RUN_FWD,
  input  wire logic             RUN_REV,
  input  wire logic             INCH_REQUEST,
  input  wire logic             HALT_N,
  input  wire logic             FAST_STOP_N,
  input  wire logic             COAST_STOP_N,
  input  wire logic             STACK_ENABLE,
  input  wire logic             TRIP_DETECT,
  // Keypad keys
  input  wire logic             KEY_RUN,
  input  wire logic             KEY_STOP,
  input  wire logic             KEY_INCH,
  input  wire logic             KEY_DIR,
  // Drive outputs
  output logic [SPD_W-1:0]      SPEED_DEMAND,
  output logic [SPD_W-1:0]      SPEED_TRIM,
  output logic                  STACK_ON,
  output logic                  MOTION_ACTIVE,
  output logic                  NO_FAULT_FLAG,
  output logic                  LATCHED_DIRECTION_OUT,
  // AXI4-Lite slave
  input  wire logic [7:0]       AXI_AWADDR,
  input  wire logic             AXI_AWVALID,
  output logic                  AXI_AWREADY,
  input  wire logic [31:0]      AXI_WDATA,
  input  wire logic [3:0]       AXI_WSTRB,
  input  wire logic             AXI_WVALID,
  output logic                  AXI_WREADY,
  output logic [1:0]            AXI_BRESP,
  output logic                  AXI_BVALID,
  input  wire logic             AXI_BREADY,
  input  wire logic [7:0]       AXI_ARADDR,
  input  wire logic             AXI_ARVALID,
  output logic                  AXI_ARREADY,
  output logic [31:0]           AXI_RDATA,
  output logic [1:0]            AXI_RRESP,
  output logic                  AXI_RVALID,
  input  wire logic             AXI_RREADY
);
  initial
  begin
    if (SPD_W < 2 || SPD_W > 16) $error("SPD_W out of range");
    if (MS_CYC < 2 || HALT_CYC < 2 || HALT_CYC >= (1 << 24)) $error("bad counts");
  end

  // ==========================================================
  // Input synchronisers, three stages, change when stages 2 and 3 agree
  logic [N_IN-1:0] s1_r, s2_r, s3_r, in_f, in_d;
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      in_f <= '0;
      in_d <= '0;
    end
    else
    begin
      s1_r <= {KEY_DIR, KEY_INCH, KEY_STOP, KEY_RUN, TRIP_DETECT, STACK_ENABLE,
               COAST_STOP_N, FAST_STOP_N, HALT_N, INCH_REQUEST, RUN_REV, RUN_FWD};
      s2_r <= s1_r;
      s3_r <= s2_r;
      in_f <= (s2_r & s3_r) | (in_f & (s2_r | s3_r));
      in_d <= in_f;
    end
  end
  wire logic [N_IN-1:0] rise = in_f & ~in_d;

  // ==========================================================
  // Register file
  logic [4:0]  ctrl_r;
  logic [15:0] ref_r, inspd_r, trim_r, accel_r, decel_r, final_r, fast_r, inper_r, dly_r;
  logic        trip_clr;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_h, w_h;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'b00 && a <= A_SPEED;
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  assign AXI_AWREADY = !aw_h && !AXI_BVALID;
  assign AXI_WREADY  = !w_h && !AXI_BVALID;
  wire logic do_wr = aw_h && w_h && !AXI_BVALID;
  assign trip_clr = do_wr && aw_q == A_CTRL && ws_q[1] && w_q[B_TRIPCLR];

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      AXI_BVALID <= 1'b0;
      AXI_BRESP <= RESP_OK;
    end
    else
    begin
      if (AXI_AWVALID && AXI_AWREADY)
      begin
        aw_h <= 1'b1;
        aw_q <= AXI_AWADDR;
      end
      if (AXI_WVALID && AXI_WREADY)
      begin
        w_h <= 1'b1;
        w_q <= AXI_WDATA;
        ws_q <= AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
        AXI_BVALID <= 1'b1;
        AXI_BRESP <= mapped(aw_q) ? RESP_OK : RESP_DEC;
      end
      else if (AXI_BREADY)
        AXI_BVALID <= 1'b0;
    end
  end

  // Configuration storage
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_r <= CTRL_RST;
      {ref_r, inspd_r, trim_r, accel_r, decel_r, fast_r, inper_r, dly_r} <= '0;
      final_r <= FINAL_RST;
    end
    else if (do_wr)
    begin
      case (aw_q)
        A_CTRL:  if (ws_q[0]) ctrl_r <= w_q[4:0];
        A_REF:   ref_r <= merge(ref_r, w_q, ws_q);
        A_INSPD: inspd_r <= merge(inspd_r, w_q, ws_q);
        A_TRIM:  trim_r <= merge(trim_r, w_q, ws_q);
        A_ACCEL: accel_r <= merge(accel_r, w_q, ws_q);
        A_DECEL: decel_r <= merge(decel_r, w_q, ws_q);
        A_FINAL: final_r <= merge(final_r, w_q, ws_q);
        A_FAST:  fast_r <= merge(fast_r, w_q, ws_q);
        A_INPER: inper_r <= merge(inper_r, w_q, ws_q);
        A_DELAY: dly_r <= merge(dly_r, w_q, ws_q);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Sequencer state and requests
  dssq_state_t st_r, st_nxt;
  logic        trip_r, loc_run_r, rem_latch_r, halt_stop_r, fstop_r, dir_r;
  logic [23:0] halt_cnt_r;
  logic        halt_evt;
  logic [31:0] ms_cnt_r;
  logic        ms_tick;
  logic [15:0] dly_cnt_r;

  wire logic local_m = ctrl_r[B_LOCAL];
  wire logic coast   = !in_f[I_COAST];
  wire logic fast    = !in_f[I_FAST] && !coast;
  wire logic kill    = coast || trip_r || !in_f[I_EN];
  wire logic both    = ctrl_r[B_TWOWIRE] && in_f[I_FWD] && in_f[I_REV];
  wire logic rem_run = !both && (in_f[I_FWD] || in_f[I_REV] || rem_latch_r);
  wire logic run_req = !halt_stop_r && (local_m ? loc_run_r : rem_run);
  wire logic inch_req = local_m ? in_f[I_KINCH] : in_f[I_INCH];
  wire logic can_go  = !kill && !fast;
  wire logic ramp_skip = (fast ? fast_r : decel_r) == ZERO16 || ctrl_r[B_FREEZE];
  wire logic dly_done = dly_cnt_r >= dly_r;
  wire dssq_state_t stop_st = ramp_skip ? ST_FINAL : ST_DECEL;

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ms_cnt_r <= '0;
      halt_cnt_r <= '0;
    end
    else
    begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      // Counts only after the line falls, so a line held low never fires
      if (in_f[I_HALT] || (halt_cnt_r == '0 && !in_d[I_HALT]))
        halt_cnt_r <= '0;
      else if (halt_cnt_r != 24'(HALT_CYC))
        halt_cnt_r <= halt_cnt_r + 1'b1;
    end
  end
  assign ms_tick = ms_cnt_r == 32'(MS_CYC - 1);
  assign halt_evt = halt_cnt_r == 24'(HALT_CYC - 1);

  // Request latches: set wins over clear, except that the stop key beats the run key
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      trip_r <= 1'b0;
      loc_run_r <= 1'b0;
      rem_latch_r <= 1'b0;
      halt_stop_r <= 1'b0;
      fstop_r <= 1'b0;
    end
    else
    begin
      trip_r <= in_f[I_TRIP] || (trip_r && !trip_clr);
      if (rise[I_KRUN] && !in_f[I_KSTOP])
        loc_run_r <= 1'b1;
      else if (in_f[I_KSTOP] || st_r == ST_IDLE && st_nxt == ST_IDLE)
        loc_run_r <= 1'b0;
      if (in_f[I_HALT] && (rise[I_FWD] || rise[I_REV]) && !both)
        rem_latch_r <= 1'b1;
      else if (!in_f[I_HALT] || st_r != ST_RUN && st_r != ST_IDLE)
        rem_latch_r <= 1'b0;
      if (halt_evt)
        halt_stop_r <= 1'b1;
      else if (st_r == ST_IDLE || st_r == ST_TRIP)
        halt_stop_r <= 1'b0;
      if (fast && (st_r == ST_RUN || st_r == ST_INCH))
        fstop_r <= 1'b1;
      else if (st_r == ST_IDLE)
        fstop_r <= 1'b0;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (trip_r) st_nxt = ST_TRIP;
        else if (can_go && run_req) st_nxt = ST_RUN;
        else if (can_go && inch_req) st_nxt = ST_INCH;
      ST_RUN, ST_INCH:
        if (kill) st_nxt = trip_r ? ST_TRIP : ST_IDLE;
        else if (fast) st_nxt = ctrl_r[B_FASTCST] ? ST_IDLE : stop_st;
        else if (st_r == ST_RUN ? !run_req : !inch_req)
          st_nxt = ctrl_r[B_STOPCST] ? ST_IDLE : stop_st;
      ST_DECEL:
        if (kill) st_nxt = trip_r ? ST_TRIP : ST_IDLE;
        else if (SPEED_DEMAND == '0) st_nxt = ST_FINAL;
      ST_FINAL:
        if (kill) st_nxt = trip_r ? ST_TRIP : ST_IDLE;
        else if (SPEED_DEMAND == '0 && SPEED_TRIM == '0) st_nxt = ST_DELAY;
      ST_DELAY:
        if (kill) st_nxt = trip_r ? ST_TRIP : ST_IDLE;
        else if (dly_done) st_nxt = ST_IDLE;
      ST_TRIP:
        if (!trip_r) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_r <= ST_IDLE;
      STACK_ON <= 1'b0;
      dly_cnt_r <= '0;
      dir_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      STACK_ON <= !kill && st_nxt != ST_IDLE && st_nxt != ST_TRIP;
      dly_cnt_r <= st_r != ST_DELAY ? '0 : dly_cnt_r + 16'(ms_tick && !dly_done);
      if (st_r == ST_IDLE && st_nxt != ST_IDLE)
        dir_r <= local_m ? in_f[I_KDIR] : in_f[I_REV];
    end
  end

  assign MOTION_ACTIVE = st_r != ST_IDLE && st_r != ST_TRIP;
  assign NO_FAULT_FLAG = st_r != ST_TRIP;
  assign LATCHED_DIRECTION_OUT = dir_r;

  // ==========================================================
  // Ramps: speed demand, then speed trim
  logic [SPD_W-1:0] spd_tgt, trim_tgt;
  logic [15:0]      spd_per, trim_per;
  logic             spd_load, trim_load;
  always_comb
  begin
    spd_tgt = '0;
    spd_per = final_r;
    spd_load = 1'b0;
    trim_tgt = SPEED_TRIM;
    trim_per = final_r;
    trim_load = 1'b0;
    case (st_r)
      ST_RUN:
      begin
        spd_tgt = ref_r[SPD_W-1:0];
        spd_per = accel_r;
        trim_tgt = trim_r[SPD_W-1:0];
        trim_load = 1'b1;
      end
      ST_INCH:
      begin
        spd_tgt = inspd_r[SPD_W-1:0];
        spd_per = inper_r;
        trim_tgt = trim_r[SPD_W-1:0];
        trim_load = 1'b1;
      end
      ST_DECEL: spd_per = fstop_r ? fast_r : decel_r;
      ST_FINAL: trim_tgt = '0;
      ST_DELAY: ;
      default:
      begin
        spd_load = 1'b1;
        trim_tgt = '0;
        trim_load = 1'b1;
      end
    endcase
  end

  dssq_ramp #(.WIDTH(SPD_W)) u_speed (
    .clk(CLK_SYS), .rst_n(ARST_N), .ms_tick(ms_tick),
    .load(spd_load), .target(spd_tgt), .period(spd_per), .value(SPEED_DEMAND));
  dssq_ramp #(.WIDTH(SPD_W)) u_trim (
    .clk(CLK_SYS), .rst_n(ARST_N), .ms_tick(ms_tick),
    .load(trim_load), .target(trim_tgt), .period(trim_per), .value(SPEED_TRIM));

  // ==========================================================
  // Read channel
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      AXI_RVALID <= 1'b0;
      AXI_RDATA <= '0;
      AXI_RRESP <= RESP_OK;
    end
    else if (AXI_ARVALID && AXI_ARREADY)
    begin
      AXI_RVALID <= 1'b1;
      AXI_RRESP <= mapped(AXI_ARADDR) ? RESP_OK : RESP_DEC;
      case (AXI_ARADDR)
        A_CTRL:   AXI_RDATA <= {27'h000_0000, ctrl_r};
        A_REF:    AXI_RDATA <= {16'h0000, ref_r};
        A_INSPD:  AXI_RDATA <= {16'h0000, inspd_r};
        A_TRIM:   AXI_RDATA <= {16'h0000, trim_r};
        A_ACCEL:  AXI_RDATA <= {16'h0000, accel_r};
        A_DECEL:  AXI_RDATA <= {16'h0000, decel_r};
        A_FINAL:  AXI_RDATA <= {16'h0000, final_r};
        A_FAST:   AXI_RDATA <= {16'h0000, fast_r};
        A_INPER:  AXI_RDATA <= {16'h0000, inper_r};
        A_DELAY:  AXI_RDATA <= {16'h0000, dly_r};
        A_STATUS: AXI_RDATA <= {17'h0_0000, st_r, trip_r, dir_r, NO_FAULT_FLAG,
                                STACK_ON, MOTION_ACTIVE, halt_stop_r, loc_run_r, rem_latch_r};
        A_SPEED:  AXI_RDATA <= {16'(SPEED_TRIM), 16'(SPEED_DEMAND)};
        default:  AXI_RDATA <= '0;
      endcase
    end
    else if (AXI_RREADY)
      AXI_RVALID <= 1'b0;
  end
  assign AXI_ARREADY = !AXI_RVALID;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  stack_enable_off_a: assert property (!in_f[I_EN] |=> !STACK_ON)
    else $error("stack on while disabled");
  coast_quench_a: assert property (coast |=> !STACK_ON && !MOTION_ACTIVE)
    else $error("coast stop did not quench");
  trip_no_fault_flag_a: assert property (in_f[I_TRIP] |=> ##1 !NO_FAULT_FLAG)
    else $error("no-fault flag stayed high on trip");
  freewheel_zero_a: assert property ($fell(MOTION_ACTIVE) |=> SPEED_DEMAND == '0)
    else $error("speed not zero after quench");
  motion_start_a: assert property ($rose(MOTION_ACTIVE) |-> $past(can_go))
    else $error("motion began without a valid start");
  run_inch_excl_a: assert property (st_r == ST_RUN |=> st_r != ST_INCH)
    else $error("run switched straight to inch");
  halt_stop_a: assert property (halt_evt && MOTION_ACTIVE |=> ##1 st_r != ST_RUN)
    else $error("halt pulse did not stop");
  delay_keep_a: assert property (st_r == ST_DELAY && !dly_done && !kill |=> STACK_ON)
    else $error("stack quenched before stop delay");
  two_wire_a: assert property (both && !local_m |-> !rem_run)
    else $error("both directions accepted");
  fast_override_a: assert property (fast && st_r == ST_RUN |=> st_r != ST_RUN)
    else $error("fast stop ignored");
endmodule
`default_nettype wire

// file: sim/dssq_panel.sv
// Model of the keypad keys and remote control pins
`default_nettype none
module dssq_panel
  import dssq_pkg::*;
#(
  parameter logic [N_IN-1:0] INIT = '0
) (
  // System
  input  wire logic       clk,
  // Levels toward the sequencer
  output logic [N_IN-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Contacts move only just after an edge
  initial pins = INIT;
  task automatic drive(input logic [N_IN-1:0] m, input logic v);
    @(posedge clk);
    pins <= v ? (pins | m) : (pins & ~m);
  endtask
  // Halt pulses stay longer than the minimum
  task automatic pulse(input logic [N_IN-1:0] m, input logic v, input int n);
    drive(m, v);
    repeat (n) @(posedge clk);
    pins <= v ? (pins & ~m) : (pins | m);
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the start/stop sequencer
`default_nettype none
module testbench
  import dssq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Pin masks
  localparam logic [11:0] FWD = 12'h001, REV = 12'h002, INCH = 12'h004, HALT = 12'h008;
  localparam logic [11:0] FAST = 12'h010, COAST = 12'h020, EN = 12'h040, TRIP = 12'h080;
  localparam logic [11:0] KRUN = 12'h100, KSTOP = 12'h200, KINCH = 12'h400;
  localparam int SPD = 0, MOT = 1, STK = 2, NOF = 3, LIM = 8000;
  logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, stack, motion, nofault, dir;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] speed;
  logic [11:0] pins;
  int          failures, tests_run;
  // ==========================================
  // Far side and device
  dssq_panel #(.INIT(EN | FAST | COAST)) u_pan (.clk(clk), .pins(pins));
  dssq_top #(.MS_CYC(200), .HALT_CYC(20)) dut (
    .CLK_SYS(clk), .ARST_N(arst_n), .RUN_FWD(pins[I_FWD]), .RUN_REV(pins[I_REV]),
    .INCH_REQUEST(pins[I_INCH]), .HALT_N(pins[I_HALT]), .FAST_STOP_N(pins[I_FAST]),
    .COAST_STOP_N(pins[I_COAST]), .STACK_ENABLE(pins[I_EN]), .TRIP_DETECT(pins[I_TRIP]),
    .KEY_RUN(pins[I_KRUN]), .KEY_STOP(pins[I_KSTOP]), .KEY_INCH(pins[I_KINCH]),
    .KEY_DIR(pins[I_KDIR]), .SPEED_DEMAND(speed), .SPEED_TRIM(), .STACK_ON(stack),
    .MOTION_ACTIVE(motion), .NO_FAULT_FLAG(nofault), .LATCHED_DIRECTION_OUT(dir),
    .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid), .AXI_AWREADY(awready), .AXI_WDATA(wdata),
    .AXI_WSTRB(wstrb), .AXI_WVALID(wvalid), .AXI_WREADY(wready), .AXI_BRESP(bresp),
    .AXI_BVALID(bvalid), .AXI_BREADY(bready), .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid),
    .AXI_ARREADY(arready), .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid),
    .AXI_RREADY(rready));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Ready is read mid-cycle, where it equals its value at the coming edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, hb;
    pa = 1'b1;
    pw = 1'b1;
    hb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(negedge clk);
      pa = pa && !awready;
      pw = pw && !wready;
      @(posedge clk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    while (!hb)
    begin
      @(negedge clk);
      hb = bvalid;
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic h;
    h = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!h)
    begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    h = 1'b0;
    while (!h)
    begin
      @(negedge clk);
      h = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
  function automatic logic [15:0] obs(input int k);
    case (k)
      SPD: return speed;
      MOT: return {15'h0000, motion};
      STK: return {15'h0000, stack};
      default: return {15'h0000, nofault};
    endcase
  endfunction
  // Waits a bounded span for an output, then compares it
  task automatic wt(input string n, input int k, input logic [15:0] v, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while (obs(k) !== v && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    chk(n, {16'h0000, obs(k)}, {16'h0000, v});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] ad [9];
    ad = '{A_REF, A_INSPD, A_TRIM, A_ACCEL, A_DECEL, A_FINAL, A_FAST, A_INPER, A_DELAY};
    wt("stack", STK, 16'h0000, 0);
    wt("nofault", NOF, 16'h0001, 0);
    axr(A_CTRL);
    chk("ctrl", rd, 32'h0000_0000);
    axr(A_FINAL);
    chk("final", rd, 32'h0000_2710);
    axr(8'h40);
    chk("unmapped", {30'h0, resp}, {30'h0, RESP_DEC});
    foreach (ad[i])
      axw(ad[i], (i == 0) ? 32'h0000_0014 : (i == 1) ? 32'h0000_0008 :
                 (i == 2) ? 32'h0000_0004 : 32'h0000_0001);
  endtask
  task automatic t_remote();
    u_pan.drive(FWD, 1'b1);
    wt("run speed", SPD, 16'h0014, LIM);
    wt("run motion", MOT, 16'h0001, 0);
    axr(A_SPEED);
    chk("trim run", rd, 32'h0004_0014);
    u_pan.drive(INCH, 1'b1);
    repeat (40) @(posedge clk);
    wt("inch ignored", SPD, 16'h0014, 0);
    u_pan.drive(INCH | FWD, 1'b0);
    wt("stop speed", SPD, 16'h0000, LIM);
    wt("delay stack", STK, 16'h0001, 0);
    wt("stop motion", MOT, 16'h0000, LIM);
    wt("quench", STK, 16'h0000, 0);
    axr(A_SPEED);
    chk("trim stop", rd, 32'h0000_0000);
    u_pan.drive(INCH, 1'b1);
    wt("inch speed", SPD, 16'h0008, LIM);
    u_pan.drive(INCH, 1'b0);
    wt("inch stop", MOT, 16'h0000, LIM);
  endtask
  task automatic t_stops();
    axw(A_CTRL, 32'h0000_0002);
    u_pan.drive(FWD, 1'b1);
    wt("free run", SPD, 16'h0014, LIM);
    u_pan.drive(FWD, 1'b0);
    wt("free stack", STK, 16'h0000, 8);
    wt("free speed", SPD, 16'h0000, 0);
    axw(A_CTRL, 32'h0000_0000);
    u_pan.drive(FWD, 1'b1);
    wt("fast run", STK, 16'h0001, LIM);
    u_pan.drive(FAST, 1'b0);
    wt("fast stop", MOT, 16'h0000, LIM);
    u_pan.drive(FAST | COAST, 1'b1);
    wt("coast run", STK, 16'h0001, LIM);
    u_pan.drive(COAST | FAST, 1'b0);
    wt("coast stack", STK, 16'h0000, 8);
    u_pan.drive(FWD, 1'b0);
    u_pan.drive(COAST | FAST, 1'b1);
    u_pan.drive(EN, 1'b0);
    u_pan.drive(FWD, 1'b1);
    repeat (40) @(posedge clk);
    wt("no enable", STK, 16'h0000, 0);
    u_pan.drive(FWD, 1'b0);
    u_pan.drive(EN, 1'b1);
  endtask
  task automatic t_trip();
    u_pan.drive(FWD, 1'b1);
    wt("trip run", STK, 16'h0001, LIM);
    u_pan.drive(TRIP, 1'b1);
    wt("trip flag", NOF, 16'h0000, 8);
    wt("trip stack", STK, 16'h0000, 0);
    u_pan.drive(TRIP, 1'b0);
    repeat (40) @(posedge clk);
    wt("trip held", STK, 16'h0000, 0);
    u_pan.drive(FWD, 1'b0);
    axw(A_CTRL, 32'h0000_0100);
    wt("trip clear", NOF, 16'h0001, 8);
  endtask
  task automatic t_wires();
    axw(A_CTRL, 32'h0000_0010);
    u_pan.drive(FWD | REV, 1'b1);
    repeat (40) @(posedge clk);
    wt("both dirs", MOT, 16'h0000, 0);
    u_pan.drive(FWD | REV, 1'b0);
    u_pan.drive(HALT, 1'b1);
    u_pan.pulse(REV, 1'b1, 10);
    repeat (40) @(posedge clk);
    wt("latched", MOT, 16'h0001, 0);
    chk("direction", {31'h0, dir}, 32'h0000_0001);
    u_pan.pulse(HALT, 1'b0, 30);
    wt("halt stop", MOT, 16'h0000, LIM);
    repeat (40) @(posedge clk);
    wt("latch clear", MOT, 16'h0000, 0);
    u_pan.pulse(INCH, 1'b1, 10);
    repeat (20) @(posedge clk);
    wt("inch unlatched", MOT, 16'h0000, LIM);
    u_pan.drive(HALT, 1'b0);
  endtask
  task automatic t_local();
    axw(A_CTRL, 32'h0000_0001);
    u_pan.pulse(KRUN, 1'b1, 10);
    repeat (40) @(posedge clk);
    wt("key run", MOT, 16'h0001, 0);
    u_pan.pulse(KSTOP, 1'b1, 10);
    wt("key stop", MOT, 16'h0000, LIM);
    u_pan.drive(KINCH, 1'b1);
    wt("key inch", SPD, 16'h0008, LIM);
    u_pan.drive(KINCH, 1'b0);
    wt("key inch stop", MOT, 16'h0000, LIM);
    u_pan.pulse(KRUN, 1'b1, 10);
    wt("local run", MOT, 16'h0001, 20);
    u_pan.pulse(FAST, 1'b0, 10);
    wt("local fast", MOT, 16'h0000, LIM);
    axw(A_CTRL, 32'h0000_0000);
  endtask
  // ==========================================
  // Verdict
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("[ERR] watchdog expected done seen timeout");
    summarize();
  end
  initial
  begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_remote();
    t_stops();
    t_trip();
    t_wires();
    t_local();
    summarize();
  end
endmodule
`default_nettype wire
